// ===== rtl/fexec_pkg.sv
/*
 * Constants for the floating execute datapath: word widths, instruction
 * codes, the deposit time-state code and loop counts.
 * Assumes a single synchronous clock domain and one data-break port.
 */
package fexec_pkg;

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int unsigned WORD_W      = 12;
	localparam int unsigned FRAC_W      = 28;
	localparam int unsigned ADDR_W      = 15;
	localparam int unsigned SHC_W       = 6;
	localparam int unsigned STATUS_W    = 12;

	// ************************************************************
	// Field positions and counts
	// ************************************************************
	localparam int unsigned FRAC_OVF_BIT = 4;
	localparam logic [SHC_W-1:0] ALIGN_LIMIT = 6'h17; // 27 octal
	localparam logic [SHC_W-1:0] MUL_STEPS   = 6'h18;
	localparam logic [SHC_W-1:0] DIV_STEPS   = 6'h1c;
	localparam logic [SHC_W-1:0] SHC_ONE     = 6'h01;
	localparam logic [SHC_W-1:0] SHC_ZERO    = 6'h00;
	localparam logic [1:0] FP_WORDS = 2'h3;
	localparam logic [1:0] DP_WORDS = 2'h2;
	localparam logic [3:0] DEPOSIT_STATE = 4'h9; // 11 octal

	// ************************************************************
	// Instruction codes
	// ************************************************************
	typedef enum logic [2:0] {
		OP_LOAD  = 3'h0,
		OP_STORE = 3'h1,
		OP_ADD   = 3'h2,
		OP_ADDM  = 3'h3,
		OP_SUB   = 3'h4,
		OP_MUL   = 3'h5,
		OP_MULM  = 3'h6,
		OP_DIV   = 3'h7
	} instr_t;

endpackage : fexec_pkg

// ===== rtl/float_execute_datapath.sv
/*
 * Execute phase of the floating coprocessor: load/store of the accumulator,
 * double-precision add/sub, floating add/sub, multiply and divide.
 * Assumes the memory answers each data-break request with mem_ack_in one
 * or more cycles later, read data valid beside the acknowledge.
 */
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps

module float_execute_datapath
	import fexec_pkg::*;
(
	// Clock, reset, enable
	input  wire logic                 sys_clk_in,
	input  wire logic                 arst_n_in,
	input  wire logic                 clk_en_in,
	// Command
	input  wire logic                 start_in,
	input  wire logic [2:0]           instr_in,
	input  wire logic                 dp_mode_in,
	input  wire logic [ADDR_W-1:0]    operand_pointer_in,
	// Accumulator seen from outside
	input  wire logic [WORD_W-1:0]    acc_exp_in,
	input  wire logic [2*WORD_W-1:0]  acc_frac_in,
	// Data-break memory port
	output logic                      mem_req_out,
	output logic                      mem_we_out,
	output logic [ADDR_W-1:0]         mem_addr_out,
	output logic [WORD_W-1:0]         mem_wdata_out,
	input  wire logic                 mem_ack_in,
	input  wire logic [WORD_W-1:0]    mem_rdata_in,
	// Results
	output logic                      busy_out,
	output logic                      done_out,
	output logic                      deposit_out,
	output logic                      exit_out,
	output logic [3:0]                time_state_out,
	output logic [FRAC_W-1:0]         o_reg_out,
	output logic [WORD_W-1:0]         quotient_low_word_out,
	output logic [SHC_W-1:0]          shift_counter_out,
	output logic                      excess_shift_flag_out,
	output logic [STATUS_W-1:0]       status_out,
	output logic [WORD_W-1:0]         floating_accumulator_exp_out,
	output logic [2*WORD_W-1:0]       floating_accumulator_frac_out
);

	// ************************************************************
	// State
	// ************************************************************
	typedef enum logic [3:0] {
		PH_IDLE, PH_FETCH, PH_STORE, PH_DPADD, PH_ALIGN, PH_SHIFT, PH_COMBINE,
		PH_MUL_SUM, PH_MUL_SHIFT, PH_DIV_TRY, PH_DIV_SHIFT, PH_FINISH, PH_DONE
	} phase_t;

	typedef struct packed {
		phase_t              ph;
		instr_t              op;
		logic                dp;
		logic [1:0]          widx;
		logic [1:0]          nwords;
		logic                req;
		logic                we;
		logic [ADDR_W-1:0]   addr;
		logic [WORD_W-1:0]   wdata;
		logic [WORD_W-1:0]   opexp;
		logic [FRAC_W-1:0]   opfrac;
		logic [WORD_W-1:0]   facexp;
		logic [2*WORD_W-1:0] facfrac;
		logic [FRAC_W-1:0]   a;
		logic [FRAC_W-1:0]   b;
		logic [FRAC_W-1:0]   o;
		logic [FRAC_W-1:0]   mq;
		logic [WORD_W-1:0]   qlw;
		logic [SHC_W-1:0]    shc;
		logic [SHC_W-1:0]    steps;
		logic                ovs;
		logic                neg;
		logic                cin;
		logic                first;
		logic [3:0]          ts;
		logic                done;
		logic                busy;
		logic                deposit;
		logic                exit;
		logic [STATUS_W-1:0] status;
	} state_t;

	state_t s_q, s_d;

	// Two's-complement magnitude, used for the multiplier and both divide operand sign strips
	function automatic logic [FRAC_W-1:0] mag(input logic [FRAC_W-1:0] v);
		mag = v[FRAC_W-1] ? (~v + {{(FRAC_W-1){1'b0}}, 1'b1}) : v;
	endfunction : mag

	function automatic logic [FRAC_W-1:0] neg_of(input logic [FRAC_W-1:0] v);
		neg_of = ~v + {{(FRAC_W-1){1'b0}}, 1'b1};
	endfunction : neg_of

	// ************************************************************
	// Next-state logic
	// ************************************************************
	logic [FRAC_W:0]   sum;
	logic [WORD_W:0]   ediff;
	logic [FRAC_W:0]   trial;
	logic [FRAC_W-1:0] afrac;

	always_comb begin
		s_d   = s_q;
		afrac = {s_q.facfrac, {(FRAC_W-2*WORD_W){1'b0}}};
		sum   = {s_q.a[FRAC_W-1], s_q.a} + {s_q.b[FRAC_W-1], s_q.b}
		        + {{FRAC_W{1'b0}}, s_q.cin};
		ediff = {s_q.facexp[WORD_W-1], s_q.facexp} - {s_q.opexp[WORD_W-1], s_q.opexp};
		trial = {1'b0, s_q.a} + {1'b0, ~s_q.b} + {{FRAC_W{1'b0}}, 1'b1};
		s_d.done = 1'b0;
		unique case (s_q.ph)
			PH_IDLE: begin
				if (start_in) begin
					s_d.op      = instr_t'(instr_in);
					s_d.dp      = dp_mode_in;
					s_d.addr    = operand_pointer_in;
					s_d.facexp  = acc_exp_in;
					s_d.facfrac = acc_frac_in;
					s_d.widx    = 2'h0;
					s_d.opexp   = '0;
					s_d.opfrac  = '0;
					s_d.exit    = 1'b0;
					s_d.ts      = 4'h0;
					s_d.nwords  = dp_mode_in ? DP_WORDS : FP_WORDS;
					s_d.req     = 1'b1;
					s_d.we      = (instr_t'(instr_in) == OP_STORE);
					s_d.wdata   = dp_mode_in ? acc_frac_in[2*WORD_W-1 -: WORD_W] : acc_exp_in;
					s_d.ph      = (instr_t'(instr_in) == OP_STORE) ? PH_STORE : PH_FETCH;
				end
			end
			PH_FETCH: begin
				// FP words: exponent, high, low; DP words: high, low
				if (mem_ack_in) begin
					if (!s_q.dp && s_q.widx == 2'h0)
						s_d.opexp = mem_rdata_in;
					else if (s_q.widx == s_q.nwords - 2'h2)
						s_d.opfrac[FRAC_W-1 -: WORD_W] = mem_rdata_in;
					else
						s_d.opfrac[FRAC_W-WORD_W-1 -: WORD_W] = mem_rdata_in;
					s_d.widx = s_q.widx + 2'h1;
					s_d.addr = s_q.addr + {{(ADDR_W-1){1'b0}}, 1'b1};
					if (s_q.widx + 2'h1 == s_q.nwords) begin
						s_d.req = 1'b0;
						s_d.ts  = 4'h1;
						unique case (s_q.op)
							OP_LOAD: s_d.ph = PH_FINISH;
							OP_MUL, OP_MULM, OP_DIV: s_d.ph = PH_FINISH;
							default: s_d.ph = s_q.dp ? PH_DPADD : PH_ALIGN;
						endcase
					end
				end
			end
			PH_STORE: begin
				if (mem_ack_in) begin
					s_d.widx = s_q.widx + 2'h1;
					s_d.addr = s_q.addr + {{(ADDR_W-1){1'b0}}, 1'b1};
					// Slice for the word after the one just accepted
					s_d.wdata = (s_q.widx + 2'h1 == s_q.nwords - 2'h2)
						? s_q.facfrac[2*WORD_W-1 -: WORD_W] : s_q.facfrac[WORD_W-1:0];
					if (s_q.widx + 2'h1 == s_q.nwords) begin
						s_d.req = 1'b0;
						s_d.we  = 1'b0;
						s_d.ph  = PH_DONE;
					end
				end
			end
			PH_DPADD: begin
				s_d.a   = afrac;
				s_d.b   = (s_q.op == OP_SUB) ? neg_of(s_q.opfrac) : s_q.opfrac;
				s_d.cin = 1'b0;
				s_d.ph  = PH_COMBINE;
			end
			PH_ALIGN: begin
				// Time state 1 mini 1/2: difference sign picks the B fraction
				s_d.qlw = s_q.opexp;
				s_d.shc = ediff[WORD_W] ? SHC_W'(neg_of({{(FRAC_W-WORD_W){1'b0}},
					ediff[WORD_W-1:0]})) : ediff[SHC_W-1:0];
				s_d.ovs = ediff[WORD_W]
					? ((~ediff[WORD_W-1:0] + 12'h001) > {6'h00, ALIGN_LIMIT})
					: (ediff[WORD_W-1:0] > {6'h00, ALIGN_LIMIT});
				s_d.cin = 1'b0;
				if (ediff[WORD_W]) begin
					// Operand exponent larger: operand fraction stays in A
					s_d.a   = (s_q.op == OP_SUB) ? ~s_q.opfrac : s_q.opfrac;
					s_d.cin = (s_q.op == OP_SUB);
					s_d.b   = afrac;
					s_d.qlw = s_q.opexp;
				end else begin
					s_d.a   = afrac;
					s_d.b   = (s_q.op == OP_SUB) ? neg_of(s_q.opfrac) : s_q.opfrac;
					s_d.qlw = s_q.facexp;
				end
				s_d.ts = 4'h3;
				s_d.ph = PH_SHIFT;
			end
			PH_SHIFT: begin
				if ((ediff[WORD_W] ? s_q.opfrac : afrac) == '0) begin
					s_d.o   = s_q.b;
					s_d.qlw = ediff[WORD_W] ? s_q.facexp : s_q.opexp;
					s_d.shc = SHC_ZERO;
					s_d.ts  = DEPOSIT_STATE;
					s_d.ph  = PH_DONE;
				end else if (s_q.ovs) begin
					s_d.b   = '0;
					s_d.shc = SHC_ZERO;
					s_d.ph  = PH_COMBINE;
				end else if (s_q.shc != SHC_ZERO) begin
					s_d.b   = $signed(s_q.b) >>> 1;
					s_d.shc = s_q.shc - SHC_ONE;
				end else
					s_d.ph = PH_COMBINE;
			end
			PH_COMBINE: begin
				// Sign of the wide sum differs from bit below: overflow
				if (sum[FRAC_W] != sum[FRAC_W-1]) begin
					if (s_q.dp) begin
						s_d.status[FRAC_OVF_BIT] = 1'b1;
						s_d.exit = 1'b1;
						s_d.ph   = PH_IDLE;
					end else begin
						s_d.o   = sum[FRAC_W:1];
						s_d.shc = SHC_ONE;
						s_d.ts  = DEPOSIT_STATE;
						s_d.ph  = PH_DONE;
					end
				end else begin
					s_d.o   = sum[FRAC_W-1:0];
					s_d.shc = SHC_ZERO;
					s_d.ts  = DEPOSIT_STATE;
					s_d.ph  = PH_DONE;
				end
			end
			PH_MUL_SUM: begin
				s_d.o     = sum[FRAC_W-1:0];
				s_d.steps = s_q.steps - SHC_ONE;
				s_d.ph    = PH_MUL_SHIFT;
			end
			PH_MUL_SHIFT: begin
				s_d.b  = s_q.mq[0] ? {1'b0, s_q.o[FRAC_W-1:1]} : {1'b0, s_q.b[FRAC_W-1:1]};
				s_d.mq = {1'b0, s_q.mq[FRAC_W-1:1]};
				s_d.ph = (s_q.steps == SHC_ZERO) ? PH_FINISH : PH_MUL_SUM;
			end
			PH_DIV_TRY: begin
				if (trial[FRAC_W]) begin
					s_d.o  = trial[FRAC_W-1:0];
					s_d.mq = {s_q.mq[FRAC_W-2:0], 1'b1};
				end else begin
					s_d.o  = s_q.a;
					s_d.mq = {s_q.mq[FRAC_W-2:0], 1'b0};
				end
				if (s_q.first) begin
					s_d.shc   = trial[FRAC_W] ? SHC_ONE : SHC_ZERO;
					s_d.first = 1'b0;
				end
				s_d.steps = s_q.steps - SHC_ONE;
				s_d.ph    = PH_DIV_SHIFT;
			end
			PH_DIV_SHIFT: begin
				s_d.o  = {s_q.o[FRAC_W-2:0], 1'b0};
				s_d.a  = {s_q.o[FRAC_W-2:0], 1'b0};
				s_d.ph = (s_q.steps == SHC_ZERO) ? PH_FINISH : PH_DIV_TRY;
			end
			PH_FINISH: begin
				s_d.ph = PH_DONE;
				if (s_q.op == OP_LOAD) begin
					s_d.facexp  = s_q.dp ? s_q.facexp : s_q.opexp;
					s_d.facfrac = s_q.opfrac[FRAC_W-1 -: 2*WORD_W];
				end else if (s_q.ts == 4'h1 && s_q.op != OP_DIV) begin
					// Multiply setup: magnitudes, carry-in forms A's negation
					s_d.mq    = mag(s_q.opfrac) >> (FRAC_W - 2*WORD_W);
					s_d.a     = afrac[FRAC_W-1] ? ~afrac : afrac;
					s_d.cin   = afrac[FRAC_W-1];
					s_d.b     = '0;
					s_d.neg   = afrac[FRAC_W-1] ^ s_q.opfrac[FRAC_W-1];
					s_d.steps = MUL_STEPS;
					s_d.ts    = 4'h2;
					s_d.ph    = PH_MUL_SUM;
				end else if (s_q.ts == 4'h1) begin
					s_d.a     = mag(afrac);
					s_d.b     = mag(s_q.opfrac);
					s_d.mq    = '0;
					s_d.neg   = afrac[FRAC_W-1] ^ s_q.opfrac[FRAC_W-1];
					s_d.steps = DIV_STEPS;
					s_d.first = 1'b1;
					s_d.ts    = 4'h2;
					s_d.ph    = PH_DIV_TRY;
				end else if (s_q.op == OP_DIV) begin
					s_d.o   = (s_q.shc == SHC_ONE) ? {1'b0, s_q.mq[FRAC_W-1:1]} : s_q.mq;
					s_d.o   = s_q.neg ? neg_of(s_d.o) : s_d.o;
					s_d.qlw = s_q.opexp;
					s_d.ts  = DEPOSIT_STATE;
				end else begin
					s_d.o   = s_q.neg ? neg_of(s_q.b) : s_q.b;
					s_d.qlw = s_q.opexp;
					s_d.shc = SHC_ZERO;
					s_d.ts  = DEPOSIT_STATE;
				end
			end
			PH_DONE: begin
				s_d.done = 1'b1;
				s_d.ph   = PH_IDLE;
			end
			default: s_d.ph = PH_IDLE;
		endcase
		// Registered so both flags leave straight from flip-flops
		s_d.busy    = (s_d.ph != PH_IDLE);
		s_d.deposit = s_d.done && (s_d.ts == DEPOSIT_STATE);
	end

	// ************************************************************
	// Registers
	// ************************************************************
	// Clock enable freezes everything, including the handshake
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			s_q <= '0;
		else if (clk_en_in)
			s_q <= s_d;
	end

	assign mem_req_out    = s_q.req;
	assign mem_we_out     = s_q.we;
	assign mem_addr_out   = s_q.addr;
	assign mem_wdata_out  = s_q.wdata;
	assign busy_out       = s_q.busy;
	assign done_out       = s_q.done;
	assign deposit_out    = s_q.deposit;
	assign exit_out       = s_q.exit;
	assign time_state_out = s_q.ts;
	assign o_reg_out      = s_q.o;
	assign quotient_low_word_out = s_q.qlw;
	assign shift_counter_out     = s_q.shc;
	assign excess_shift_flag_out = s_q.ovs;
	assign status_out            = s_q.status;
	assign floating_accumulator_exp_out  = s_q.facexp;
	assign floating_accumulator_frac_out = s_q.facfrac;

endmodule : float_execute_datapath

// ===== verif/fexec_asserts.sv
/* Port checker for the floating execute datapath.
   Assumes it is bound to the datapath top and sees only its ports. */
`timescale 1ns/1ps
module fexec_asserts
	import fexec_pkg::*;
(
	input wire logic                sys_clk_in,
	input wire logic                arst_n_in,
	input wire logic                clk_en_in,
	input wire logic                start_in,
	input wire logic [2:0]          instr_in,
	input wire logic                dp_mode_in,
	input wire logic [ADDR_W-1:0]   operand_pointer_in,
	input wire logic                mem_req_out,
	input wire logic                mem_we_out,
	input wire logic [ADDR_W-1:0]   mem_addr_out,
	input wire logic                mem_ack_in,
	input wire logic                busy_out,
	input wire logic                done_out,
	input wire logic                deposit_out,
	input wire logic                exit_out,
	input wire logic [3:0]          time_state_out,
	input wire logic [SHC_W-1:0]    shift_counter_out,
	input wire logic [STATUS_W-1:0] status_out
);
	logic [2:0]        op_q;
	logic              dp_q;
	logic [ADDR_W-1:0] ptr_q;
	logic [1:0]        cnt_q;
	logic              ldst;
	assign ldst = op_q inside {OP_LOAD, OP_STORE};
	// Command taken at start, words acknowledged since then
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			{op_q, dp_q, ptr_q, cnt_q} <= '0;
		end else if (start_in && !busy_out && clk_en_in) begin
			{op_q, dp_q, ptr_q} <= {instr_in, dp_mode_in, operand_pointer_in};
			cnt_q <= 2'h0;
		end else if (mem_req_out && mem_ack_in) begin
			cnt_q <= cnt_q + 2'h1;
		end
	end
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!arst_n_in);
	sequence s_next_word;
		mem_req_out && mem_ack_in ##1 mem_req_out && ldst;
	endsequence
	sequence s_waiting;
		mem_req_out && !mem_ack_in;
	endsequence
	property p_hold;
		s_waiting |=> mem_req_out && $stable(mem_addr_out) && $stable(mem_we_out);
	endproperty
	property p_first_addr;
		$rose(mem_req_out) && ldst |-> mem_addr_out == ptr_q;
	endproperty
	property p_addr_step;
		s_next_word |-> mem_addr_out == $past(mem_addr_out) + 1'b1;
	endproperty
	property p_word_count;
		done_out && ldst |-> cnt_q == (dp_q ? DP_WORDS : FP_WORDS);
	endproperty
	property p_store_we;
		mem_req_out && ldst |-> mem_we_out == (op_q == OP_STORE);
	endproperty
	property p_ovf_exit;
		$rose(exit_out) |-> dp_q && !done_out ##[0:1] status_out[FRAC_OVF_BIT];
	endproperty
	property p_deposit;
		deposit_out |-> done_out && time_state_out == DEPOSIT_STATE && !ldst;
	endproperty
	property p_add_end;
		done_out && !dp_q && op_q inside {OP_ADD, OP_ADDM, OP_SUB}
			|-> deposit_out && shift_counter_out <= SHC_ONE;
	endproperty
	property p_muldiv_end;
		done_out && op_q inside {OP_MUL, OP_MULM, OP_DIV} |-> deposit_out;
	endproperty
	a_hold: assert property (p_hold) else $error("request moved before ack");
	a_first_addr: assert property (p_first_addr) else $error("bad first address");
	a_addr_step: assert property (p_addr_step) else $error("address not consecutive");
	a_word_count: assert property (p_word_count) else $error("wrong word count");
	a_store_we: assert property (p_store_we) else $error("write enable wrong");
	a_ovf_exit: assert property (p_ovf_exit) else $error("exit without overflow bit");
	a_deposit: assert property (p_deposit) else $error("deposit state code wrong");
	a_add_end: assert property (p_add_end) else $error("add end state wrong");
	a_muldiv_end: assert property (p_muldiv_end) else $error("no deposit entry");
endmodule : fexec_asserts

// ===== verif/fexec_mem_model.sv
/* Core memory answering data-break requests, prompt or slow.
   Assumes one request at a time, held until acknowledged. */
`timescale 1ns/1ps
module fexec_mem_model
	import fexec_pkg::*;
(
	// Clock and reset
	input  wire logic              sys_clk_in,
	input  wire logic              arst_n_in,
	// Request
	input  wire logic              req_in,
	input  wire logic              we_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [WORD_W-1:0] wdata_in,
	input  wire logic [1:0]        wait_in,
	// Answer
	output logic                   ack_out,
	output logic [WORD_W-1:0]      rdata_out
);
	logic [WORD_W-1:0] mem [0:63];
	logic [1:0]        cnt_q;
	// One word per ack; read data are valid only beside it
	always @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			{ack_out, cnt_q, rdata_out} <= '0;
		end else begin
			ack_out <= 1'b0;
			rdata_out <= ~rdata_out; // Stale data never look valid
			if (req_in && !ack_out && cnt_q == wait_in) begin
				ack_out <= 1'b1;
				cnt_q <= 2'h0;
				rdata_out <= mem[addr_in[5:0]];
				if (we_in)
					mem[addr_in[5:0]] <= wdata_in;
			end else if (req_in && !ack_out) begin
				cnt_q <= cnt_q + 2'h1;
			end
		end
	end
endmodule : fexec_mem_model

// ===== verif/float_execute_datapath_tb.sv
/* Self-checking bench for the floating execute datapath.
   Assumes package, memory model and checker are compiled first. */
`timescale 1ns/1ps
module float_execute_datapath_tb
	import fexec_pkg::*;
;
	logic                sys_clk_in, arst_n_in, clk_en_in, start_in, dp_mode_in;
	logic [2:0]          instr_in;
	logic [ADDR_W-1:0]   operand_pointer_in, mem_addr_out;
	logic [WORD_W-1:0]   acc_exp_in, mem_wdata_out, mem_rdata_in, quotient_low_word_out;
	logic [WORD_W-1:0]   floating_accumulator_exp_out;
	logic [2*WORD_W-1:0] acc_frac_in, floating_accumulator_frac_out;
	logic                mem_req_out, mem_we_out, mem_ack_in, busy_out, done_out;
	logic                deposit_out, exit_out, excess_shift_flag_out;
	logic [3:0]          time_state_out;
	logic [FRAC_W-1:0]   o_reg_out;
	logic [SHC_W-1:0]    shift_counter_out;
	logic [STATUS_W-1:0] status_out;
	logic [1:0]          mem_wait;
	int                  n_mismatch, n_checks, k;
	float_execute_datapath dut (.sys_clk_in, .arst_n_in, .clk_en_in, .start_in, .instr_in,
		.dp_mode_in, .operand_pointer_in, .acc_exp_in, .acc_frac_in, .mem_req_out,
		.mem_we_out, .mem_addr_out, .mem_wdata_out, .mem_ack_in, .mem_rdata_in, .busy_out,
		.done_out, .deposit_out, .exit_out, .time_state_out, .o_reg_out,
		.quotient_low_word_out, .shift_counter_out, .excess_shift_flag_out, .status_out,
		.floating_accumulator_exp_out, .floating_accumulator_frac_out);
	fexec_mem_model mem (.sys_clk_in, .arst_n_in, .req_in(mem_req_out), .we_in(mem_we_out),
		.addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .wait_in(mem_wait),
		.ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
	// 200 MHz clock
	always #2.5 sys_clk_in = ~sys_clk_in;
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	task automatic cmp(input string nm, input logic [27:0] e, input logic [27:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	// Operand in three words: exponent, high and low fraction
	task automatic put(input int a, input logic [11:0] e, input logic [23:0] f);
		mem.mem[a] = e;
		mem.mem[a+1] = f[23:12];
		mem.mem[a+2] = f[11:0];
	endtask : put
	// One instruction, bounded wait for done or exit
	task automatic go(input instr_t op, input logic dp, input logic [14:0] p,
		input logic [11:0] ae, input logic [23:0] af);
		int i;
		@(posedge sys_clk_in);
		{instr_in, dp_mode_in, operand_pointer_in} <= {op, dp, p};
		{acc_exp_in, acc_frac_in, start_in} <= {ae, af, 1'b1};
		@(posedge sys_clk_in);
		start_in <= 1'b0;
		for (i = 0; i < 400; i++) begin
			@(posedge sys_clk_in);
			#1;
			if (done_out === 1'b1 || exit_out === 1'b1)
				break;
		end
		@(posedge sys_clk_in);
		#1;
		if (i == 400) begin
			n_mismatch++;
			$display("CHECK FAILED completion expected done seen none");
			report_and_stop();
		end
	endtask : go
	task automatic add_instr(input instr_t op, input logic [11:0] ae, input logic [23:0] af,
		input logic [11:0] oe, input logic [23:0] of, input logic [27:0] eo,
		input logic [11:0] eq, input logic es, input logic ex);
		put(40, oe, of);
		go(op, 1'b0, 15'd40, ae, af);
		cmp("add frac", eo, o_reg_out);
		cmp("add exp", 28'(eq), 28'(quotient_low_word_out));
		cmp("add count", 28'(es), 28'(shift_counter_out));
		cmp("add excess", 28'(ex), 28'(excess_shift_flag_out));
	endtask : add_instr
	// Main sequence
	initial begin
		{sys_clk_in, arst_n_in, start_in, dp_mode_in, instr_in} = '0;
		{operand_pointer_in, acc_exp_in, acc_frac_in, mem_wait} = '0;
		clk_en_in = 1'b1;
		n_mismatch = 0;
		n_checks = 0;
		for (k = 0; k < 64; k++)
			mem.mem[k] = 12'h555;
		repeat (16) @(posedge sys_clk_in);
		arst_n_in <= 1'b1;
		mem_wait <= 2'd2;
		put(8, 12'h005, 24'h5a3c96);
		go(OP_LOAD, 1'b0, 15'd8, 12'h000, 24'h000000);
		cmp("load exp", 28'h5, 28'(floating_accumulator_exp_out));
		cmp("load frac", 28'h5a3c96, 28'(floating_accumulator_frac_out));
		go(OP_LOAD, 1'b1, 15'd9, 12'h000, 24'h000000);
		cmp("dp load frac", 28'h5a3c96, 28'(floating_accumulator_frac_out));
		$display("test loads done");
		mem_wait <= 2'd0;
		go(OP_STORE, 1'b0, 15'd20, 12'h123, 24'h456789);
		cmp("store w0", 28'h123, 28'(mem.mem[20]));
		cmp("store w2", 28'h789, 28'(mem.mem[22]));
		go(OP_STORE, 1'b1, 15'd24, 12'h123, 24'habcdef);
		cmp("dp store w1", 28'hdef, 28'(mem.mem[25]));
		cmp("dp store w2", 28'h555, 28'(mem.mem[26]));
		$display("test stores done");
		put(30, 12'h000, 24'h001000);
		go(OP_ADD, 1'b1, 15'd30, 12'h000, 24'h7fffff);
		cmp("dp exit", 28'h1, 28'(exit_out));
		cmp("dp status", 28'h1, 28'(status_out[FRAC_OVF_BIT]));
		$display("test overflow done");
		add_instr(OP_ADD, 12'h002, 24'h400000, 12'h001, 24'h400000, 28'h6000000, 12'h2, 0, 0);
		add_instr(OP_ADD, 12'h001, 24'h400000, 12'h002, 24'h400000, 28'h6000000, 12'h2, 0, 0);
		add_instr(OP_ADD, 12'h001, 24'h400000, 12'h001, 24'h400000, 28'h4000000, 12'h1, 1, 0);
		add_instr(OP_SUB, 12'h002, 24'h400000, 12'h001, 24'h400000, 28'h2000000, 12'h2, 0, 0);
		add_instr(OP_ADD, 12'h028, 24'h400000, 12'h001, 24'h400000, 28'h4000000, 12'h28, 0, 1);
		add_instr(OP_ADD, 12'h001, 24'h000000, 12'h001, 24'h400000, 28'h4000000, 12'h1, 0, 0);
		add_instr(OP_SUB, 12'h001, 24'h400000, 12'h002, 24'h400000, 28'he000000, 12'h2, 0, 0);
		add_instr(OP_SUB, 12'h001, 24'h400000, 12'h002, 24'h000000, 28'h4000000, 12'h1, 0, 0);
		$display("test float add done");
		for (k = 0; k < 4; k++) begin
			put(40, 12'h003, k[0] ? 24'hc00000 : 24'h400000);
			go(OP_MUL, 1'b0, 15'd40, 12'h001, k[1] ? 24'hc00000 : 24'h400000);
			// Twenty-four halvings leave the product one place low
			cmp("mul frac", (k[0] ^ k[1]) ? 28'hf000000 : 28'h1000000, o_reg_out);
			cmp("mul exp", 28'h3, 28'(quotient_low_word_out));
			put(40, 12'h003, k[0] ? 24'hc00000 : 24'h400000);
			go(OP_DIV, 1'b0, 15'd40, 12'h001, k[1] ? 24'he00000 : 24'h200000);
			cmp("div frac", (k[0] ^ k[1]) ? 28'hc000000 : 28'h4000000, o_reg_out);
			cmp("div exp", 28'h3, 28'(quotient_low_word_out));
			cmp("div count", 28'h0, 28'(shift_counter_out));
		end
		put(40, 12'h003, 24'h200000);
		go(OP_DIV, 1'b0, 15'd40, 12'h001, 24'h400000);
		cmp("div big count", 28'h1, 28'(shift_counter_out));
		$display("test mul div done");
		report_and_stop();
	end
endmodule : float_execute_datapath_tb
bind float_execute_datapath fexec_asserts u_chk (.sys_clk_in, .arst_n_in, .clk_en_in,
	.start_in, .instr_in, .dp_mode_in, .operand_pointer_in, .mem_req_out, .mem_we_out,
	.mem_addr_out, .mem_ack_in, .busy_out, .done_out, .deposit_out, .exit_out,
	.time_state_out, .shift_counter_out, .status_out);
